/* File: dv/blpw_backlight_tb.sv */
// Purpose: self-checking bench of the backlight pwm block
// Assumes: 250 MHz clock, table rows run with dimming off
// Notes:   pin width is judged through the led driver model
`timescale 1ns/10ps
module blpw_backlight_tb;
  typedef struct {
    logic [7:0] sl, au, ae, amb, md, ad, mn, fe, fv, man, ex, eb, ea;
  } blpw_row_t;
  logic i_mclk = 0, i_sys_rst = 1, i_cmd_wr = 0, i_cmd_rd = 0;
  logic i_sleep_out = 1, i_auto_brightness_select = 0;
  logic i_ambient_light_control = 0, i_forced_adaptive_duty_enable = 0;
  logic i_frame_start = 0, i_dimming_enable = 0, i_rising_dim_type = 0;
  logic i_falling_dim_type = 0, i_pwm_clock_select = 0;
  logic [15:0] i_cmd_addr = '0, hl;
  logic [7:0] i_cmd_wdata = '0, i_ambient_duty = '0, i_adaptive_duty = '0;
  logic [7:0] i_minimum_duty_limit = '0, i_forced_adaptive_duty_value = '0;
  logic [7:0] i_pwm_divider = 8'h01, o_cmd_rdata, o_ambient_duty_readback;
  logic [7:0] o_adaptive_duty_readback;
  logic [3:0] i_rising_frames_per_step = '0, i_falling_frames_per_step = '0;
  logic [3:0] i_rising_step_size = '0, i_falling_step_size = '0;
  logic [2:0] i_fixed_time_step_count = '0, i_off_mode_step_count = '0;
  logic [2:0] i_still_ui_mode_step_count = '0, i_moving_mode_step_count = '0;
  logic [1:0] i_adaptive_mode = '0;
  logic [4:0] i_duty_offset = '0;
  logic o_cmd_rvalid, o_backlight_pwm_out;
  int n_errors = 0, n_tests = 0;
  blpw_row_t rows[6];

  blpw_backlight dut (
    .i_mclk, .i_sys_rst, .i_cmd_wr, .i_cmd_rd, .i_cmd_addr, .i_cmd_wdata,
    .o_cmd_rdata, .o_cmd_rvalid, .i_sleep_out, .i_auto_brightness_select,
    .i_ambient_light_control, .i_ambient_duty, .i_adaptive_mode,
    .i_adaptive_duty, .i_minimum_duty_limit, .i_forced_adaptive_duty_enable,
    .i_forced_adaptive_duty_value, .i_frame_start, .i_dimming_enable,
    .i_rising_dim_type, .i_falling_dim_type, .i_rising_frames_per_step,
    .i_falling_frames_per_step, .i_rising_step_size, .i_falling_step_size,
    .i_fixed_time_step_count, .i_off_mode_step_count,
    .i_still_ui_mode_step_count, .i_moving_mode_step_count,
    .i_pwm_clock_select, .i_pwm_divider, .i_duty_offset,
    .o_ambient_duty_readback, .o_adaptive_duty_readback, .o_backlight_pwm_out
  );
  blpw_led_drv drv (.i_mclk, .i_pwm(o_backlight_pwm_out), .o_high_len(hl));

  // free-running master clock
  always #2 i_mclk = ~i_mclk;

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // strobes are one-cycle pulses, released on the next edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_cmd_wr <= 1;
    i_cmd_addr <= a;
    i_cmd_wdata <= d;
    @(posedge i_mclk);
    i_cmd_wr <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_cmd_rd <= 1;
    i_cmd_addr <= a;
    @(posedge i_mclk);
    i_cmd_rd <= 0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, o_cmd_rvalid});
    chk("rdata", {8'h00, e}, {8'h00, o_cmd_rdata});
  endtask
  // one frame pulse, then read the applied duty
  task automatic step(input logic [7:0] e);
    @(posedge i_mclk);
    i_frame_start <= 1;
    @(posedge i_mclk);
    i_frame_start <= 0;
    repeat (2) @(posedge i_mclk);
    rd(16'h5200, e);
  endtask

  initial begin
    rows = '{
      '{1, 0, 0, 0, 0, 0, 0, 0, 0, 8'h80, 8'h80, 8'h80, 8'hFF},
      '{1, 1, 0, 0, 1, 8'h7F, 0, 0, 0, 8'h80, 8'h40, 8'h80, 8'h7F},
      '{1, 1, 1, 8'hC0, 2, 8'h3F, 0, 0, 0, 8'h80, 8'h30, 8'hC0, 8'h3F},
      '{1, 0, 0, 0, 3, 8'h0F, 8'h7F, 0, 0, 8'hFF, 8'h7F, 8'hFF, 8'h7F},
      '{1, 0, 0, 0, 1, 8'hFF, 0, 1, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'h3F},
      '{0, 0, 0, 0, 0, 0, 0, 0, 0, 8'hFF, 8'h00, 8'hFF, 8'hFF}};
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 0;
    foreach (rows[i]) begin
      @(posedge i_mclk);
      i_sleep_out <= rows[i].sl[0];
      i_auto_brightness_select <= rows[i].au[0];
      i_ambient_light_control <= rows[i].ae[0];
      i_ambient_duty <= rows[i].amb;
      i_adaptive_mode <= rows[i].md[1:0];
      i_adaptive_duty <= rows[i].ad;
      i_minimum_duty_limit <= rows[i].mn;
      i_forced_adaptive_duty_enable <= rows[i].fe[0];
      i_forced_adaptive_duty_value <= rows[i].fv;
      wr(i[0] ? 16'h0051 : 16'h5100, rows[i].man);
      repeat (2) @(posedge i_mclk);
      rd(i[0] ? 16'h0052 : 16'h5200, rows[i].ex);
      chk("amb", 16'(rows[i].eb), 16'(o_ambient_duty_readback));
      chk("ratio", 16'(rows[i].ea), 16'(o_adaptive_duty_readback));
    end
    // rising slope, two frames per step, last step clamped
    i_sleep_out <= 1;
    wr(16'h5100, 8'h0A);
    repeat (3) @(posedge i_mclk);
    i_dimming_enable <= 1;
    i_rising_dim_type <= 1;
    i_rising_step_size <= 4'h7;
    i_rising_frames_per_step <= 4'h1;
    wr(16'h5100, 8'h14);
    repeat (3) @(posedge i_mclk);
    rd(16'h5200, 8'h0A);
    step(8'h0A);
    step(8'h11);
    step(8'h11);
    step(8'h14);
    // falling fixed-time, two steps of one frame each
    wr(16'h5100, 8'h0A);
    repeat (3) @(posedge i_mclk);
    step(8'h0F);
    step(8'h0A);
    rd(16'h5300, 8'h00);
    // adaptive change with base untouched: off-mode count, steps of 2, third step clamped
    i_off_mode_step_count <= 3'h1;
    i_forced_adaptive_duty_enable <= 1'b1;
    i_forced_adaptive_duty_value <= 8'h7F;
    repeat (3) @(posedge i_mclk);
    step(8'h08);
    step(8'h06);
    step(8'h05);
    // high time: (5 + 1 + offset 2) ticks of 25 * 4 clocks; a full
    // period at the new rate is waited out so no mixed pulse is judged
    i_duty_offset <= 5'h02;
    i_pwm_clock_select <= 1'b1;
    i_pwm_divider <= 8'h04;
    repeat (27000) @(posedge i_mclk);
    chk("pwm_high", 16'd800, hl);
    // mid-run reset: pin dark, ratio readback full, duty back at zero
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk("rst_pin", 16'h0000, 16'(o_backlight_pwm_out));
    chk("rst_ratio", 16'h00FF, 16'(o_adaptive_duty_readback));
    i_sys_rst <= 1'b0;
    rd(16'h5200, 8'h00);
    tally_and_finish;
  end
endmodule // blpw_backlight_tb

/* File: dv/blpw_led_drv.sv */
// Purpose: led driver model, measures pwm high time
// Assumes: pin active high, sampled on i_mclk
// Notes:   reports length of the last complete high pulse
`timescale 1ns/10ps
module blpw_led_drv (
  // clock and pin
  input  wire logic        i_mclk,
  input  wire logic        i_pwm,
  // measured high time in clock cycles
  output logic [15:0]      o_high_len
);
  logic [15:0] run_reg;

  // count high cycles, publish on the falling edge of the pin
  always_ff @(posedge i_mclk) begin
    if (i_pwm) begin
      run_reg <= run_reg + 16'h0001;
    end else begin
      if (run_reg != 16'h0000) begin
        o_high_len <= run_reg;
      end
      run_reg <= 16'h0000;
    end
  end
endmodule // blpw_led_drv

/* File: logic/blpw_backlight.sv */
//------------------------------------------------------------------------------
// Purpose: backlight brightness combining, dimming and pwm output
// Assumes: command strobes, frame pulse and settings come from i_mclk logic
// Notes:   ambient filtering and adaptive algorithm live outside
//
// What this block does
// - auto without ambient: manual times adaptive
// - auto with ambient: ambient times adaptive
// - manual value written at 5100h or 51h
// - read 5200h or 52h gives applied duty
// - adaptive duty never below minimum limit
// - forced enable replaces adaptive duty
// - sleep-in turns all off, backlight dark
// - one enable bit gates all dimming
// - dim every level change except sleep-in, directions separate
// - type bit: 0 fixed-time, 1 fixed-slope
// - frames per step equals field plus one
// - fixed-time step count from count field
// - fixed-slope moves duty by step size
// - slope steps equal difference over size
// - adaptive slope uses the common fields
// - adaptive fixed-time uses per-mode step count
// - clock select and divider set frequency
// - divider sets frequency, offset compensates duty
// - offset lengthens high time for settling
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module blpw_backlight (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  // command port
  input  wire logic       i_cmd_wr,
  input  wire logic       i_cmd_rd,
  input  wire logic [15:0] i_cmd_addr,
  input  wire logic [7:0] i_cmd_wdata,
  output logic [7:0]      o_cmd_rdata,
  output logic            o_cmd_rvalid,
  // brightness selection
  input  wire logic       i_sleep_out,
  input  wire logic       i_auto_brightness_select,
  input  wire logic       i_ambient_light_control,
  input  wire logic [7:0] i_ambient_duty,
  // content-adaptive control
  input  wire logic [1:0] i_adaptive_mode,
  input  wire logic [7:0] i_adaptive_duty,
  input  wire logic [7:0] i_minimum_duty_limit,
  input  wire logic       i_forced_adaptive_duty_enable,
  input  wire logic [7:0] i_forced_adaptive_duty_value,
  // dimming settings
  input  wire logic       i_frame_start,
  input  wire logic       i_dimming_enable,
  input  wire logic       i_rising_dim_type,
  input  wire logic       i_falling_dim_type,
  input  wire logic [3:0] i_rising_frames_per_step,
  input  wire logic [3:0] i_falling_frames_per_step,
  input  wire logic [3:0] i_rising_step_size,
  input  wire logic [3:0] i_falling_step_size,
  input  wire logic [2:0] i_fixed_time_step_count,
  input  wire logic [2:0] i_off_mode_step_count,
  input  wire logic [2:0] i_still_ui_mode_step_count,
  input  wire logic [2:0] i_moving_mode_step_count,
  // pwm settings
  input  wire logic       i_pwm_clock_select,
  input  wire logic [7:0] i_pwm_divider,
  input  wire logic [4:0] i_duty_offset,
  // outputs
  output logic [7:0]      o_ambient_duty_readback,
  output logic [7:0]      o_adaptive_duty_readback,
  output logic            o_backlight_pwm_out
);

  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  blpw_pkg::blpw_dim_state_t  state_reg;
  blpw_pkg::blpw_adapt_mode_t adapt_mode;
  logic [7:0]  manual_brightness_reg;
  logic [7:0]  applied_reg;
  logic [7:0]  dim_target_reg;
  logic [7:0]  step_amt_reg;
  logic        dir_up_reg;
  logic [7:0]  base_seen_reg;
  logic [3:0]  frame_cnt_reg;
  logic [7:0]  base_duty;
  logic [7:0]  adapt_raw;
  logic [7:0]  adapt_duty;
  logic [16:0] product;
  logic [7:0]  target_duty;
  logic [7:0]  diff;
  logic        rising;
  logic        slope_type;
  logic [2:0]  count_field;
  logic [3:0]  shift;
  logic [15:0] ceil_sum;
  logic [7:0]  start_amt;
  logic [3:0]  fps;
  logic        step_fire;
  logic [8:0]  step_up;
  logic [8:0]  step_dn;
  logic        wr_manual;
  logic        rd_applied;
  logic        pwm_tick;
  logic        pwm_level;

  //----------------------------------------------------------------------------
  // command decode
  //----------------------------------------------------------------------------
  // both the long and the serial-link address reach the same register
  assign wr_manual  = i_cmd_wr && ((i_cmd_addr == blpw_pkg::ADDR_MANUAL_WR) ||
                      (i_cmd_addr == blpw_pkg::ADDR_MANUAL_WR_SL));
  assign rd_applied = i_cmd_rd && ((i_cmd_addr == blpw_pkg::ADDR_APPLIED_RD) ||
                      (i_cmd_addr == blpw_pkg::ADDR_APPLIED_RD_SL));

  // manual brightness register
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      manual_brightness_reg <= blpw_pkg::MANUAL_RESET;
    end else if (wr_manual) begin
      manual_brightness_reg <= i_cmd_wdata;
    end
  end

  // read answer one cycle later; unmapped reads return zero
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cmd_rdata  <= 8'h00;
      o_cmd_rvalid <= 1'b0;
    end else begin
      o_cmd_rvalid <= i_cmd_rd;
      o_cmd_rdata  <= rd_applied ? applied_reg : 8'h00;
    end
  end

  //----------------------------------------------------------------------------
  // brightness combining
  //----------------------------------------------------------------------------
  // ambient result only counts while ambient control is on
  always_comb begin
    base_duty = manual_brightness_reg;
    if (i_auto_brightness_select && i_ambient_light_control) begin
      base_duty = i_ambient_duty;
    end
  end

  // adaptive ratio: full in off mode, forced value wins, floor applied
  assign adapt_mode = blpw_pkg::blpw_adapt_mode_t'(i_adaptive_mode);
  always_comb begin
    adapt_raw = i_adaptive_duty;
    if (i_forced_adaptive_duty_enable) begin
      adapt_raw = i_forced_adaptive_duty_value;
    end else if (adapt_mode == blpw_pkg::ADAPT_OFF) begin
      adapt_raw = blpw_pkg::DUTY_FULL;
    end
    adapt_duty = adapt_raw;
    if (adapt_raw < i_minimum_duty_limit) begin
      adapt_duty = i_minimum_duty_limit;
    end
  end

  // ratio times ratio; the +1 keeps a full ratio exact
  assign product     = base_duty * ({1'b0, adapt_duty} + 9'h001);
  assign target_duty = i_sleep_out ? product[15:8]
                                   : blpw_pkg::DUTY_ZERO;

  //----------------------------------------------------------------------------
  // dimming step planning
  //----------------------------------------------------------------------------
  // a change with the base untouched came from the adaptive side
  always_comb begin
    rising      = (target_duty > applied_reg);
    diff        = rising ? target_duty - applied_reg
                         : applied_reg - target_duty;
    slope_type  = rising ? i_rising_dim_type : i_falling_dim_type;
    count_field = i_fixed_time_step_count;
    if (base_duty == base_seen_reg) begin
      unique case (adapt_mode)
        blpw_pkg::ADAPT_OFF:    count_field = i_off_mode_step_count;
        blpw_pkg::ADAPT_UI,
        blpw_pkg::ADAPT_STILL:  count_field = i_still_ui_mode_step_count;
        blpw_pkg::ADAPT_MOVING: count_field = i_moving_mode_step_count;
      endcase
    end
    shift    = blpw_pkg::blpw_step_shift(count_field);
    ceil_sum = ({8'h00, diff} + (16'h0001 << shift) - 16'h0001) >> shift;
    if (slope_type) begin
      // one size field per direction, shared by all sources
      start_amt = rising ? {4'h0, i_rising_step_size}
                         : {4'h0, i_falling_step_size};
    end else begin
      start_amt = ceil_sum[7:0];
    end
    if (start_amt == 8'h00) begin
      start_amt = blpw_pkg::STEP_MIN;
    end
  end

  //----------------------------------------------------------------------------
  // frame pacing
  //----------------------------------------------------------------------------
  // step length is field plus one frames, per direction
  assign fps       = dir_up_reg ? i_rising_frames_per_step
                                : i_falling_frames_per_step;
  assign step_fire = (state_reg == blpw_pkg::DIM_RUN) && i_frame_start &&
                     (frame_cnt_reg == fps);

  // frame counter restarts with each dimming run
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frame_cnt_reg <= blpw_pkg::FRAME_CNT_RST;
    end else if (state_reg != blpw_pkg::DIM_RUN) begin
      frame_cnt_reg <= blpw_pkg::FRAME_CNT_RST;
    end else if (i_frame_start) begin
      frame_cnt_reg <= step_fire ? blpw_pkg::FRAME_CNT_RST
                                 : frame_cnt_reg + 4'h1;
    end
  end

  //----------------------------------------------------------------------------
  // dimming engine
  //----------------------------------------------------------------------------
  assign step_up = {1'b0, applied_reg} + {1'b0, step_amt_reg};
  assign step_dn = {1'b0, applied_reg} - {1'b0, step_amt_reg};

  // a target that moves mid-run restarts the plan from the present duty,
  // so slope steps always count as difference over size
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg      <= blpw_pkg::DIM_IDLE;
      applied_reg    <= blpw_pkg::DUTY_ZERO;
      dim_target_reg <= blpw_pkg::DUTY_ZERO;
      step_amt_reg   <= blpw_pkg::STEP_MIN;
      dir_up_reg     <= 1'b0;
      base_seen_reg  <= blpw_pkg::DUTY_ZERO;
    end else if (!i_sleep_out || !i_dimming_enable) begin
      // no dimming at all: sleep goes dark at once
      state_reg      <= blpw_pkg::DIM_IDLE;
      applied_reg    <= target_duty;
      dim_target_reg <= target_duty;
      base_seen_reg  <= base_duty;
    end else begin
      unique case (state_reg)
        blpw_pkg::DIM_IDLE: begin
          if (target_duty != applied_reg) begin
            state_reg      <= blpw_pkg::DIM_RUN;
            dim_target_reg <= target_duty;
            dir_up_reg     <= rising;
            step_amt_reg   <= start_amt;
            base_seen_reg  <= base_duty;
          end
        end
        blpw_pkg::DIM_RUN: begin
          if (target_duty != dim_target_reg) begin
            state_reg <= blpw_pkg::DIM_IDLE;
          end else if (step_fire && dir_up_reg) begin
            if (step_up >= {1'b0, dim_target_reg}) begin
              applied_reg <= dim_target_reg;
              state_reg   <= blpw_pkg::DIM_IDLE;
            end else begin
              applied_reg <= step_up[7:0];
            end
          end else if (step_fire) begin
            if (step_dn[8] || (step_dn[7:0] <= dim_target_reg)) begin
              applied_reg <= dim_target_reg;
              state_reg   <= blpw_pkg::DIM_IDLE;
            end else begin
              applied_reg <= step_dn[7:0];
            end
          end
        end
      endcase
    end
  end

  // readbacks of the two ratios
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ambient_duty_readback  <= blpw_pkg::DUTY_ZERO;
      o_adaptive_duty_readback <= blpw_pkg::DUTY_FULL;
    end else begin
      o_ambient_duty_readback  <= base_duty;
      o_adaptive_duty_readback <= adapt_duty;
    end
  end

  //----------------------------------------------------------------------------
  // pwm generation
  //----------------------------------------------------------------------------
  blpw_prescale u_prescale (
    .i_mclk             (i_mclk),
    .i_sys_rst          (i_sys_rst),
    .i_pwm_clock_select (i_pwm_clock_select),
    .i_pwm_divider      (i_pwm_divider),
    .o_tick             (pwm_tick)
  );

  blpw_pwm_core u_pwm_core (
    .i_mclk        (i_mclk),
    .i_sys_rst     (i_sys_rst),
    .i_tick        (pwm_tick),
    .i_duty        (applied_reg),
    .i_duty_offset (i_duty_offset),
    .o_pwm         (pwm_level)
  );

  // extra flop keeps the pin a direct register output
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_backlight_pwm_out <= 1'b0;
    end else begin
      o_backlight_pwm_out <= pwm_level;
    end
  end

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_MANUAL_WRITE: assert property (
    wr_manual |=> manual_brightness_reg == $past(i_cmd_wdata))
    else $error("manual brightness write not stored");

  AST_READBACK: assert property (
    rd_applied |=> o_cmd_rvalid && o_cmd_rdata == $past(applied_reg))
    else $error("readback differs from applied duty");

  AST_AMBIENT_SEL: assert property (
    i_auto_brightness_select && i_ambient_light_control
      |-> base_duty == i_ambient_duty)
    else $error("ambient result not selected");

  AST_MANUAL_SEL: assert property (
    !i_ambient_light_control |-> base_duty == manual_brightness_reg)
    else $error("manual value not selected");

  AST_MIN_LIMIT: assert property (
    adapt_duty >= i_minimum_duty_limit)
    else $error("adaptive duty below minimum limit");

  AST_FORCED: assert property (
    i_forced_adaptive_duty_enable &&
      i_forced_adaptive_duty_value >= i_minimum_duty_limit
      |-> adapt_duty == i_forced_adaptive_duty_value)
    else $error("forced duty not applied");

  AST_SLEEP_DARK: assert property (
    !i_sleep_out ##1 !i_sleep_out |-> applied_reg == blpw_pkg::DUTY_ZERO)
    else $error("backlight on during sleep-in");

  AST_NO_DIM: assert property (
    i_sleep_out && !i_dimming_enable |=> applied_reg == $past(target_duty))
    else $error("duty did not jump with dimming off");

  AST_STEP_ON_FRAME: assert property (
    $past(i_sleep_out) && $past(i_dimming_enable) && $changed(applied_reg)
      |-> $past(step_fire))
    else $error("duty moved outside a frame step");

  AST_NO_OVERSHOOT: assert property (
    state_reg == blpw_pkg::DIM_RUN && dir_up_reg
      && target_duty == dim_target_reg |-> applied_reg <= dim_target_reg)
    else $error("rising dim passed its target");

  COV_RISE_DONE: cover property (
    state_reg == blpw_pkg::DIM_RUN && dir_up_reg ##1
    state_reg == blpw_pkg::DIM_IDLE);
  COV_FALL_STEP: cover property (step_fire && !dir_up_reg);
  COV_READ: cover property (rd_applied ##1 o_cmd_rdata != 8'h00);

endmodule // blpw_backlight

/* File: logic/blpw_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: shared constants and types of the backlight pwm dimming block
// Assumes: master clock of 250 MHz
// Notes:   all widths fixed, nothing here is a process
//------------------------------------------------------------------------------
package blpw_pkg;

  //----------------------------------------------------------------------------
  // clock and pwm timing
  //----------------------------------------------------------------------------
  localparam int unsigned MCLK_PERIOD_PS  = 4000;
  localparam int unsigned MCLK_HZ         = 1_000_000_000 / MCLK_PERIOD_PS * 1000;
  localparam int unsigned PWM_OSC_SLOW_HZ = 5_000_000;
  localparam int unsigned PWM_OSC_FAST_HZ = 10_000_000;
  localparam logic [7:0]  OSC_DIV_SLOW    = 8'(MCLK_HZ / PWM_OSC_SLOW_HZ);
  localparam logic [7:0]  OSC_DIV_FAST    = 8'(MCLK_HZ / PWM_OSC_FAST_HZ);
  localparam logic [8:0]  PWM_PERIOD_CNT  = 9'h100;

  //----------------------------------------------------------------------------
  // command addresses, long and serial-link forms
  //----------------------------------------------------------------------------
  localparam logic [15:0] ADDR_MANUAL_WR     = 16'h5100;
  localparam logic [15:0] ADDR_MANUAL_WR_SL  = 16'h0051;
  localparam logic [15:0] ADDR_APPLIED_RD    = 16'h5200;
  localparam logic [15:0] ADDR_APPLIED_RD_SL = 16'h0052;

  //----------------------------------------------------------------------------
  // duty scale and reset values
  //----------------------------------------------------------------------------
  localparam logic [7:0]  DUTY_FULL     = 8'hff;
  localparam logic [7:0]  DUTY_ZERO     = 8'h00;
  localparam logic [7:0]  MANUAL_RESET  = 8'h00;
  localparam logic [7:0]  STEP_MIN      = 8'h01;
  localparam logic [3:0]  FRAME_CNT_RST = 4'h0;

  //----------------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ADAPT_OFF,
    ADAPT_UI,
    ADAPT_STILL,
    ADAPT_MOVING
  } blpw_adapt_mode_t;

  typedef enum logic {
    DIM_IDLE,
    DIM_RUN
  } blpw_dim_state_t;

  // fixed-time step-count field to log2 of steps: 1 gives 4 steps
  function automatic logic [3:0] blpw_step_shift(input logic [2:0] field);
    blpw_step_shift = {1'b0, field} + 4'h1;
  endfunction

endpackage

/* File: logic/blpw_prescale.sv */
//------------------------------------------------------------------------------
// Purpose: makes the pwm operating clock tick and divides it by the divider
// Assumes: select and divider are quasi-static settings on i_mclk
// Notes:   divider value 0 is treated as 1
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module blpw_prescale (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  // settings
  input  wire logic       i_pwm_clock_select,
  input  wire logic [7:0] i_pwm_divider,
  // one-cycle tick per pwm count
  output logic            o_tick
);

  logic [7:0] osc_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic [7:0] osc_lim;
  logic [7:0] div_lim;
  logic       osc_tick;

  // terminal counts of both stages
  assign osc_lim  = i_pwm_clock_select ? blpw_pkg::OSC_DIV_FAST - 8'h01
                                       : blpw_pkg::OSC_DIV_SLOW - 8'h01;
  assign div_lim  = (i_pwm_divider == 8'h00) ? 8'h00 : i_pwm_divider - 8'h01;
  assign osc_tick = (osc_cnt_reg >= osc_lim);

  // operating clock stage, 5 or 10 MHz equivalent
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osc_cnt_reg <= 8'h00;
    end else if (osc_tick) begin
      osc_cnt_reg <= 8'h00;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end
  end

  // divider stage, tick registered so the output is a flop
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_cnt_reg <= 8'h00;
      o_tick      <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (osc_tick) begin
        if (div_cnt_reg >= div_lim) begin
          div_cnt_reg <= 8'h00;
          o_tick      <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 8'h01;
        end
      end
    end
  end

endmodule // blpw_prescale

/* File: logic/blpw_pwm_core.sv */
//------------------------------------------------------------------------------
// Purpose: 256-count pwm period with duty and settling offset
// Assumes: one tick per count from the prescaler
// Notes:   duty is latched at period start so no runt pulses appear
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module blpw_pwm_core (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  // count tick and duty
  input  wire logic       i_tick,
  input  wire logic [7:0] i_duty,
  input  wire logic [4:0] i_duty_offset,
  // pin
  output logic            o_pwm
);

  logic [7:0] cnt_reg;
  logic [8:0] high_reg;
  logic [9:0] high_next;

  // duty n means n+1 high counts; zero stays dark, offset adds settling time
  always_comb begin
    high_next = {2'b00, i_duty} + 10'h001 + {5'h00, i_duty_offset};
    if (i_duty == blpw_pkg::DUTY_ZERO) begin
      high_next = 10'h000;
    end else if (high_next > {1'b0, blpw_pkg::PWM_PERIOD_CNT}) begin
      high_next = {1'b0, blpw_pkg::PWM_PERIOD_CNT};
    end
  end

  // period counter and latched high length
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg  <= 8'h00;
      high_reg <= 9'h000;
    end else if (i_tick) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == blpw_pkg::DUTY_FULL) begin
        high_reg <= high_next[8:0];
      end
    end
  end

  // output flop
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pwm <= 1'b0;
    end else begin
      o_pwm <= ({1'b0, cnt_reg} < high_reg);
    end
  end

endmodule // blpw_pwm_core
